// ===== src/dls_led_encoder.v
/*
  Diagnostic LED status encoder: turns drive status inputs into on, off,
  slow and fast flash patterns on ready, bus-fault, link and safety LEDs,
  with an AXI4-Lite register slave and a masked level interrupt.
  Assumes all status inputs are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dls_consts.vh"

// Behaviour
// - Ready LED orange after power-up until state is determined, then red/green.
// - LEDs use on, off, slow flash and fast flash (link LED has no fast flash), rates distinct.
// - Ready LED steady green when no fault is present.
// - Ready LED slow green flash during commissioning or factory reset.
// - Ready LED fast red flash while a fault is present.
// - Bad memory card: ready and bus-fault LEDs both fast red flash.
// - Link LED steady green while PROFINET communication works.
// - Link LED slow green flash while device naming is active.
// - Link LED off without PROFINET communication.
// - RS485: bus-fault on with data, red slow idle bus, red fast no activity.
// - PROFIBUS: bus-fault off in cyclic exchange or protocol select zero.
// - PROFIBUS: bus-fault red slow flash on configuration fault.
// - PROFIBUS: bus-fault red fast on no exchange, baud search, no connection.
// - Safety LED steady yellow when enabled but no function active.
// - Safety LED slow yellow flash when active without safety fault.
// - Safety LED fast yellow flash on safety function fault.
module dls_led_encoder (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Drive status
  input  wire        stateDetermined,
  input  wire        faultPresent,
  input  wire        commissioning,
  input  wire        badMemoryCard,
  // PROFINET
  input  wire        pnCommOk,
  input  wire        deviceNaming,
  // RS485
  input  wire        rsProcessData,
  input  wire        rsBusActive,
  // PROFIBUS
  input  wire        pbCyclicData,
  input  wire        pbConfigFault,
  input  wire        pbNoExchange,
  input  wire        pbBaudSearch,
  input  wire        pbNoConnection,
  // Safety
  input  wire        safeEnabled,
  input  wire        safeActive,
  input  wire        safeFault,
  // LEDs: colour code for ready and bus-fault, link is on/off, safety is yellow on/off
  output reg  [1:0]  readyLed,
  output reg  [1:0]  bus_fault_indicator,
  output reg         link_indicator,
  output reg         safetyLed,
  // Interrupt
  output reg         irq,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [15:0] TICK_MAX    = `DLS_TICK_CYCLES - 16'h0001;
  localparam [9:0]  SLOW_HALF   = `DLS_SLOW_HALF_MS;
  localparam [9:0]  FAST_HALF   = `DLS_FAST_HALF_MS;
  // Registers decode on address bits 3:2 only, so offsets wrap
  localparam [3:0]  REG_STATUS  = `DLS_REG_STATUS;
  localparam [3:0]  REG_CTRL    = `DLS_REG_CTRL;
  localparam [3:0]  REG_IRQSTAT = `DLS_REG_IRQSTAT;
  localparam [3:0]  REG_IRQMASK = `DLS_REG_IRQMASK;
  localparam [31:0] CTRL_RESET  = `DLS_CTRL_RESET;

  reg  [15:0] tickCnt;
  reg  [9:0]  slowCnt;
  reg  [9:0]  fastCnt;
  reg         slowPhase;
  reg         fastPhase;
  reg  [7:0]  fieldbus_protocol_select;
  reg         busIsPb;
  reg  [`DLS_IRQ_WIDTH-1:0] irqStat;
  reg  [`DLS_IRQ_WIDTH-1:0] irqMask;
  reg  [`DLS_IRQ_WIDTH-1:0] evPrev;
  reg  [1:0]  next_readyLed;
  reg  [1:0]  next_busLed;
  reg         next_linkLed;
  reg         next_safetyLed;
  reg  [1:0]  readyPat;
  reg  [1:0]  busPat;
  reg  [1:0]  linkPat;
  reg  [1:0]  safePat;
  reg  [3:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         awHeld;
  reg         wHeld;
  wire [`DLS_IRQ_WIDTH-1:0] evNow;
  wire [`DLS_IRQ_WIDTH-1:0] evRise;
  wire [`DLS_IRQ_WIDTH-1:0] next_irqStat;
  wire        busLoss;
  wire        pbFast;
  wire        tickHit;
  wire        rdStatClr;
  wire [31:0] statusWord;

  // One millisecond tick feeds both flash dividers
  // Phases start dark; first toggle comes a full half period after reset
  assign tickHit = (tickCnt == TICK_MAX);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt   <= 16'h0000;
      slowCnt   <= 10'h000;
      fastCnt   <= 10'h000;
      slowPhase <= 1'b0;
      fastPhase <= 1'b0;
    end else begin
      tickCnt <= tickHit ? 16'h0000 : tickCnt + 16'h0001;
      if (tickHit) begin
        if (slowCnt == SLOW_HALF - 10'h001) begin
          slowCnt   <= 10'h000;
          slowPhase <= ~slowPhase;
        end else begin
          slowCnt <= slowCnt + 10'h001;
        end
        if (fastCnt == FAST_HALF - 10'h001) begin
          fastCnt   <= 10'h000;
          fastPhase <= ~fastPhase;
        end else begin
          fastCnt <= fastCnt + 10'h001;
        end
      end
    end
  end

  function lit;
    input [1:0] pat;
    input       slowP;
    input       fastP;
    begin
      case (pat)
        `DLS_PAT_ON:   lit = 1'b1;
        `DLS_PAT_SLOW: lit = slowP;
        `DLS_PAT_FAST: lit = fastP;
        default:       lit = 1'b0;
      endcase
    end
  endfunction

  // Missing cyclic exchange counts as no data exchange
  assign pbFast = pbNoExchange | pbBaudSearch | pbNoConnection | ~pbCyclicData;

  always @* begin
    readyPat = `DLS_PAT_ON;
    busPat   = `DLS_PAT_OFF;
    linkPat  = `DLS_PAT_OFF;
    safePat  = `DLS_PAT_OFF;
    next_readyLed = `DLS_COL_GREEN;
    next_busLed   = `DLS_COL_OFF;
    // Ready LED, severity order card, fault, commissioning, normal
    if (!stateDetermined) begin
      next_readyLed = `DLS_COL_ORANGE;
    end else if (badMemoryCard) begin
      readyPat      = `DLS_PAT_FAST;
      next_readyLed = `DLS_COL_RED;
    end else if (faultPresent) begin
      readyPat      = `DLS_PAT_FAST;
      next_readyLed = `DLS_COL_RED;
    end else if (commissioning) begin
      readyPat = `DLS_PAT_SLOW;
    end else begin
      readyPat = `DLS_PAT_ON;
    end
    if (!lit(readyPat, slowPhase, fastPhase))
      next_readyLed = `DLS_COL_OFF;
    // Bus-fault LED; RS485 steady-on shown green, the only non-red state
    if (badMemoryCard) begin
      busPat = `DLS_PAT_FAST;
      next_busLed = `DLS_COL_RED;
    end else if (fieldbus_protocol_select == 8'h00) begin
      busPat = `DLS_PAT_OFF;
    end else if (busIsPb) begin
      next_busLed = `DLS_COL_RED;
      if (pbConfigFault)
        busPat = `DLS_PAT_SLOW;
      else if (pbFast)
        busPat = `DLS_PAT_FAST;
      else
        busPat = `DLS_PAT_OFF;
    end else begin
      next_busLed = `DLS_COL_RED;
      if (rsProcessData) begin
        busPat = `DLS_PAT_ON;
        next_busLed = `DLS_COL_GREEN;
      end else if (rsBusActive)
        busPat = `DLS_PAT_SLOW;
      else
        busPat = `DLS_PAT_FAST;
    end
    if (!lit(busPat, slowPhase, fastPhase))
      next_busLed = `DLS_COL_OFF;
    // Link LED
    if (deviceNaming)
      linkPat = `DLS_PAT_SLOW;
    else if (pnCommOk)
      linkPat = `DLS_PAT_ON;
    else
      linkPat = `DLS_PAT_OFF;
    next_linkLed = lit(linkPat, slowPhase, fastPhase);
    // Safety LED
    if (safeFault)
      safePat = `DLS_PAT_FAST;
    else if (safeActive)
      safePat = `DLS_PAT_SLOW;
    else if (safeEnabled)
      safePat = `DLS_PAT_ON;
    else
      safePat = `DLS_PAT_OFF;
    next_safetyLed = lit(safePat, slowPhase, fastPhase);
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readyLed            <= `DLS_COL_ORANGE;
      bus_fault_indicator <= `DLS_COL_OFF;
      link_indicator      <= 1'b0;
      safetyLed           <= 1'b0;
    end else begin
      readyLed            <= next_readyLed;
      bus_fault_indicator <= next_busLed;
      link_indicator      <= next_linkLed;
      safetyLed           <= next_safetyLed;
    end
  end

  // Interrupt events: rising edges of fault conditions
  // Bus loss counts only while a fieldbus is selected: no false edge after reset
  assign busLoss = (fieldbus_protocol_select != 8'h00) &
                   (busIsPb ? pbFast : ~rsBusActive);
  assign evNow = {busLoss, safeFault, badMemoryCard, faultPresent};
  assign evRise = evNow & ~evPrev;
  assign rdStatClr = s_axi_arvalid & s_axi_arready &
                     (s_axi_araddr[3:2] == REG_IRQSTAT[3:2]);
  // New event beats the read clear in the same cycle
  assign next_irqStat = (rdStatClr ? {`DLS_IRQ_WIDTH{1'b0}} : irqStat) | evRise;

  // Status word shows live inputs the encoder acts on
  assign statusWord = {23'h000000, safeFault, safeActive, safeEnabled, deviceNaming,
                       pnCommOk, badMemoryCard, commissioning, faultPresent,
                       stateDetermined};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evPrev  <= {`DLS_IRQ_WIDTH{1'b0}};
      irqStat <= {`DLS_IRQ_WIDTH{1'b0}};
      irq     <= 1'b0;
    end else begin
      evPrev  <= evNow;
      irqStat <= next_irqStat;
      irq     <= |(next_irqStat & irqMask);
    end
  end

  // AXI4-Lite write path: address and data latched independently
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DLS_RESP_OKAY;
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 4'h0;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
      fieldbus_protocol_select <= CTRL_RESET[`DLS_CTRL_PROTO_MSB:`DLS_CTRL_PROTO_LSB];
      busIsPb <= CTRL_RESET[`DLS_CTRL_BUSSEL];
      irqMask <= `DLS_IRQMASK_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DLS_RESP_OKAY;
        // Every word is mapped, so the error response is never taken
        case (awAddr[3:2])
          REG_CTRL[3:2]: begin
            if (wStrb[0])
              fieldbus_protocol_select <= wData[`DLS_CTRL_PROTO_MSB:`DLS_CTRL_PROTO_LSB];
            if (wStrb[1])
              busIsPb <= wData[`DLS_CTRL_BUSSEL];
          end
          REG_IRQMASK[3:2]: begin
            if (wStrb[0])
              irqMask <= wData[`DLS_IRQ_WIDTH-1:0];
          end
          REG_STATUS[3:2], REG_IRQSTAT[3:2]: s_axi_bresp <= `DLS_RESP_OKAY;
          default: s_axi_bresp <= `DLS_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DLS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `DLS_RESP_OKAY;
        // Status read returns the value before its clear
        case (s_axi_araddr[3:2])
          REG_STATUS[3:2]:  s_axi_rdata <= statusWord;
          REG_CTRL[3:2]:    s_axi_rdata <= {23'h000000, busIsPb, fieldbus_protocol_select};
          REG_IRQSTAT[3:2]: s_axi_rdata <= {28'h0000000, irqStat};
          REG_IRQMASK[3:2]: s_axi_rdata <= {28'h0000000, irqMask};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/dls_consts.vh
/*
  Constants for the diagnostic LED status encoder: register offsets,
  field positions, reset values, flash timing and colour codes.
  Assumes inclusion by bare name from the design file.
*/
`ifndef DLS_CONSTS_VH
`define DLS_CONSTS_VH

// Register byte offsets
`define DLS_REG_STATUS   4'h0
`define DLS_REG_CTRL     4'h4
`define DLS_REG_IRQSTAT  4'h8
`define DLS_REG_IRQMASK  4'hc
`define DLS_REG_LEDS     4'h0
// Status register field positions (RO)
`define DLS_ST_DETERMINED 0
`define DLS_ST_FAULT      1
`define DLS_ST_COMMISSION 2
`define DLS_ST_BADCARD    3
`define DLS_ST_PNLINK     4
`define DLS_ST_NAMING     5
`define DLS_ST_SAFEEN     6
`define DLS_ST_SAFEACT    7
`define DLS_ST_SAFEFLT    8
// Control register fields
`define DLS_CTRL_PROTO_LSB 0
`define DLS_CTRL_PROTO_MSB 7
`define DLS_CTRL_BUSSEL    8
`define DLS_CTRL_RESET     32'h0000_0000
// Interrupt bits
`define DLS_IRQ_FAULT   0
`define DLS_IRQ_BADCARD 1
`define DLS_IRQ_SAFEFLT 2
`define DLS_IRQ_BUSLOSS 3
`define DLS_IRQ_WIDTH   4
`define DLS_IRQMASK_RESET 4'h0
// Flash timing: half periods in ms, clock in kHz
`define DLS_CLK_KHZ      40000
`define DLS_SLOW_HALF_MS 10'h1f4
`define DLS_FAST_HALF_MS 10'h07d
`define DLS_TICK_CYCLES  16'h9c40
// Pattern codes
`define DLS_PAT_OFF  2'h0
`define DLS_PAT_ON   2'h1
`define DLS_PAT_SLOW 2'h2
`define DLS_PAT_FAST 2'h3
// Colour codes
`define DLS_COL_OFF    2'h0
`define DLS_COL_GREEN  2'h1
`define DLS_COL_RED    2'h2
`define DLS_COL_ORANGE 2'h3
// AXI responses
`define DLS_RESP_OKAY   2'h0
`define DLS_RESP_SLVERR 2'h2

`endif

// ===== bench/dls_panel_model.sv
/*
  Operator panel model: watches the ready LED as a person would.
  Assumes LED outputs synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dls_panel_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // LED seen
  input  wire logic [1:0] readyLed,
  // Sticky: orange was seen since power-up
  output var  logic       seenOrange
);
  // Operator only notes what was shown, never resets on own
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) seenOrange <= 1'b0;
    else if (readyLed == 2'h3) seenOrange <= 1'b1;
  end
endmodule
`default_nettype wire

// ===== bench/dls_led_checker.sv
/*
  Checker for dls_led_encoder LED patterns, bound to the top ports.
  Assumes one clock; flash phases start dark after reset.
*/
`timescale 1ns/10ps
`default_nettype none
module dls_led_checker (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Status
  input  wire logic       stateDetermined,
  input  wire logic       faultPresent,
  input  wire logic       commissioning,
  input  wire logic       badMemoryCard,
  input  wire logic       pnCommOk,
  input  wire logic       deviceNaming,
  input  wire logic       safeEnabled,
  input  wire logic       safeActive,
  input  wire logic       safeFault,
  // LEDs
  input  wire logic [1:0] readyLed,
  input  wire logic [1:0] bus_fault_indicator,
  input  wire logic       link_indicator,
  input  wire logic       safetyLed
);
  wire ok = stateDetermined && !badMemoryCard;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_orange_early: assert property (!stateDetermined |=> readyLed == 2'h3)
    else $error("ready LED not orange");
  a_ready_green: assert property (ok && !faultPresent && !commissioning |=> readyLed == 2'h1)
    else $error("ready LED not steady green");
  a_commission_green: assert property (ok && !faultPresent && commissioning |=> readyLed inside {2'h0, 2'h1})
    else $error("ready LED not green flash");
  a_fault_red: assert property (ok && faultPresent |=> readyLed inside {2'h0, 2'h2})
    else $error("ready LED not red flash");
  a_card_red: assert property (stateDetermined && badMemoryCard |=> readyLed inside {2'h0, 2'h2} && bus_fault_indicator inside {2'h0, 2'h2})
    else $error("bad card pattern wrong");
  a_link_steady: assert property (pnCommOk && !deviceNaming |=> link_indicator)
    else $error("link LED not lit");
  a_link_dark: assert property (!pnCommOk && !deviceNaming |=> !link_indicator)
    else $error("link LED not dark");
  a_safe_steady: assert property (safeEnabled && !safeActive && !safeFault |=> safetyLed)
    else $error("safety LED not lit");
  a_safe_dark: assert property (!safeEnabled && !safeActive && !safeFault |=> !safetyLed)
    else $error("safety LED not dark");
endmodule
bind dls_led_encoder dls_led_checker i_chk (.clk(clk), .rst_b(rst_b),
  .stateDetermined(stateDetermined), .faultPresent(faultPresent),
  .commissioning(commissioning), .badMemoryCard(badMemoryCard), .pnCommOk(pnCommOk),
  .deviceNaming(deviceNaming), .safeEnabled(safeEnabled), .safeActive(safeActive),
  .safeFault(safeFault), .readyLed(readyLed), .bus_fault_indicator(bus_fault_indicator),
  .link_indicator(link_indicator), .safetyLed(safetyLed));
`default_nettype wire

// ===== bench/test_diagnostic_led_status_encoder.sv
/*
  Testbench for dls_led_encoder: status stimulus and AXI4-Lite accesses.
  Assumes design, panel model and checker compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_diagnostic_led_status_encoder;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] stim = 16'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire  [1:0]  readyLed, busLed, bresp, rresp;
  wire  [31:0] rdata;
  wire         linkLed, safeLed, irq, awready, wready, bvalid, arready, rvalid, seenOrange;
  int          fail_count = 0, compares = 0;

  always #12.5 clk = ~clk;

  dls_led_encoder i_dut (.clk(clk), .rst_b(rst_b),
    .stateDetermined(stim[15]), .faultPresent(stim[14]), .commissioning(stim[13]),
    .badMemoryCard(stim[12]), .pnCommOk(stim[11]), .deviceNaming(stim[10]),
    .rsProcessData(stim[9]), .rsBusActive(stim[8]), .pbCyclicData(stim[7]),
    .pbConfigFault(stim[6]), .pbNoExchange(stim[5]), .pbBaudSearch(stim[4]),
    .pbNoConnection(stim[3]), .safeEnabled(stim[2]), .safeActive(stim[1]),
    .safeFault(stim[0]), .readyLed(readyLed), .bus_fault_indicator(busLed),
    .link_indicator(linkLed), .safetyLed(safeLed), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  dls_panel_model i_panel (.clk(clk), .rst_b(rst_b), .readyLed(readyLed),
    .seenOrange(seenOrange));

  task automatic check(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Slave may take address and data on different edges
  task automatic axiWrite(input [3:0] a, input [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
      if (wready && !wd) begin wd = 1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge clk);
    check({30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask

  task automatic axiRead(input [3:0] a, output [31:0] d);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    check({30'h0, rresp}, 32'h0);
    rready <= 1'b0;
  endtask

  // LED vector {ready, bus, link, safety}; flashes still in dark phase
  task automatic led(input [15:0] v, input [5:0] exp);
    @(posedge clk);
    stim <= v;
    repeat (3) @(posedge clk);
    #1 check({26'h0, readyLed, busLed, linkLed, safeLed}, {26'h0, exp});
  endtask

  task complete_run;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #1000000;
    fail_count++;
    complete_run;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    axiRead(4'h4, rd); check(rd, 32'h0);
    axiRead(4'hc, rd); check(rd, 32'h0);
    led(16'h0000, 6'h30);
    check({31'h0, seenOrange}, 32'h1);
    led(16'h8000, 6'h10);
    led(16'ha000, 6'h00);
    led(16'hc000, 6'h00);
    led(16'he000, 6'h00);
    led(16'h8804, 6'h13);
    axiRead(4'h0, rd); check(rd, 32'h51);
    led(16'h8c06, 6'h10);
    led(16'h8007, 6'h10);
    $display("test ready link safety done");
    axiWrite(4'h4, 32'h1);
    led(16'h8200, 6'h14);
    led(16'h9200, 6'h00);
    led(16'h8100, 6'h10);
    axiWrite(4'h4, 32'h101);
    axiRead(4'h4, rd); check(rd, 32'h101);
    led(16'h8080, 6'h10);
    led(16'h8040, 6'h10);
    axiWrite(4'h4, 32'h100);
    led(16'h8020, 6'h10);
    $display("test bus fault done");
    axiWrite(4'hc, 32'h1);
    led(16'h8000, 6'h10);
    axiRead(4'h8, rd); check(rd, 32'hf);
    led(16'hc000, 6'h00);
    check({31'h0, irq}, 32'h1);
    axiRead(4'h8, rd); check(rd & 32'h1, 32'h1);
    repeat (3) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    axiWrite(4'hc, 32'h0);
    led(16'h8000, 6'h10);
    led(16'hc000, 6'h00);
    check({31'h0, irq}, 32'h0);
    axiRead(4'h8, rd); check(rd & 32'h1, 32'h1);
    $display("test interrupt done");
    complete_run;
  end
endmodule
`default_nettype wire
